// ===== hdl/dual_aux_pwm_timer.sv
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - two channels, each with 8-bit period, on-time and own pin
// - mode bit 8 set selects independent, clear selects offset
// - independent mode: each channel uses only its own registers
// - period lasts two clocks times period value plus one
// - every period value from zero to all ones is accepted
// - on-time is two clocks times on-time value; zero gives zero
// - on-time beyond period gives full duty in both modes
// - offset mode: both share channel a period, own on-times
// - offset mode: b rises two clocks times (period b+1) after a
// - registers may be written at any time
// - new on-time takes effect at the next cycle start
// - period write zeroes timer a (and b in independent mode) and starts fresh cycles
// - reset: offset mode, periods all ones, on-times zero
// - time unit is two core clock periods
module dual_aux_pwm_timer (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [aux_pwm_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [aux_pwm_pkg::DATA_W-1:0]  pwdata,
  output      logic [aux_pwm_pkg::DATA_W-1:0]  prdata,
  output      logic                            pready,
  output      logic                            pslverr,
  output      logic                            pwm_out_a,
  output      logic                            pwm_out_b
);
  import aux_pwm_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]        period_a;
    logic [7:0]        period_b;
    logic [7:0]        ontime_a;
    logic [7:0]        ontime_b;
    logic              indep;
    logic              restart;
    logic              div;
    logic [DATA_W-1:0] rdata;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic       wr_access;
  logic       rd_setup;
  logic       tick;
  reg_sel_t   sel;
  logic [DATA_W-1:0] status_word;

  pwm_chan_if ch_a ();
  pwm_chan_if ch_b ();

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic reg_sel_t decode (
    input logic [ADDR_W-1:0] addr
  );
    reg_sel_t s;
    case (addr)
      PERIOD_A_OFS:  s = SEL_PERIOD_A;
      PERIOD_B_OFS:  s = SEL_PERIOD_B;
      ONTIME_A_OFS:  s = SEL_ONTIME_A;
      ONTIME_B_OFS:  s = SEL_ONTIME_B;
      MODE_CTRL_OFS: s = SEL_MODE;
      STATUS_OFS:    s = SEL_STATUS;
      default:       s = SEL_NONE;
    endcase
    return s;
  endfunction : decode

  function automatic logic is_error (
    input logic [ADDR_W-1:0] addr,
    input logic              write
  );
    // status is read only; writes to it are refused
    return (decode(addr) == SEL_NONE) ||
           (write && decode(addr) == SEL_STATUS);
  endfunction : is_error

  assign sel       = decode(paddr);
  assign wr_access = psel && penable && pwrite &&
                     !is_error(paddr, 1'b1);
  assign rd_setup  = psel && !penable && !pwrite;

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  // zero wait states; read data is staged in setup
  assign pready  = 1'b1;
  assign pslverr = psel && penable && is_error(paddr, pwrite);
  assign prdata  = st.rdata;

  always_comb begin
    status_word = '0;
    status_word[STAT_PWM_A_BIT] = ch_a.pwm;
    status_word[STAT_PWM_B_BIT] = ch_b.pwm;
    status_word[STAT_CNT_A_LSB +: 8] = ch_a.count;
    status_word[STAT_CNT_B_LSB +: 8] = ch_b.count;
  end

  // ----------------------------------------
  // register file and divider
  // ----------------------------------------
  always_comb begin
    next_st         = st;
    next_st.restart = 1'b0;

    if (wr_access) begin
      case (sel)
        SEL_PERIOD_A: begin
          next_st.period_a = pwdata[7:0];
          next_st.restart  = 1'b1;
        end
        SEL_PERIOD_B: begin
          next_st.period_b = pwdata[7:0];
          next_st.restart  = 1'b1;
        end
        SEL_ONTIME_A: begin
          next_st.ontime_a = pwdata[7:0];
        end
        SEL_ONTIME_B: begin
          next_st.ontime_b = pwdata[7:0];
        end
        SEL_MODE: begin
          next_st.indep   = pwdata[MODE_INDEP_BIT];
          next_st.restart = 1'b1;
        end
        default: begin
          next_st.restart = 1'b0;
        end
      endcase
    end

    if (rd_setup) begin
      case (sel)
        SEL_PERIOD_A: next_st.rdata = {24'h000000, st.period_a};
        SEL_PERIOD_B: next_st.rdata = {24'h000000, st.period_b};
        SEL_ONTIME_A: next_st.rdata = {24'h000000, st.ontime_a};
        SEL_ONTIME_B: next_st.rdata = {24'h000000, st.ontime_b};
        SEL_MODE: begin
          next_st.rdata = '0;
          next_st.rdata[MODE_INDEP_BIT] = st.indep;
        end
        SEL_STATUS:   next_st.rdata = status_word;
        default:      next_st.rdata = '0;
      endcase
    end

    // tick spans two core clock periods
    if (st.restart || tick) begin
      next_st.div = 1'b0;
    end else begin
      next_st.div = st.div + 1'b1;
    end
  end

  // restart cycle itself never ticks, so the
  // first count after a restart is a full unit long
  assign tick = !st.restart && (st.div == TICK_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.period_a <= PERIOD_RST;
      st.period_b <= PERIOD_RST;
      st.ontime_a <= ONTIME_RST;
      st.ontime_b <= ONTIME_RST;
      st.indep    <= MODE_RST;
      st.restart  <= 1'b0;
      st.div      <= 1'b0;
      st.rdata    <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // channel wiring
  // ----------------------------------------
  // channel a always runs on its own period
  // full 8-bit period range, no clamping
  assign ch_a.tick       = tick;
  assign ch_a.restart    = st.restart;
  assign ch_a.period     = st.period_a;
  assign ch_a.init_count = 8'h00;
  assign ch_a.ontime_new = st.ontime_a;

  // independent: b uses its own period
  // offset: b starts period_b+1 ticks late
  // period_b above period_a is not guarded
  assign ch_b.tick       = tick;
  assign ch_b.restart    = st.restart;
  assign ch_b.period     = st.indep ? st.period_b : st.period_a;
  assign ch_b.init_count = st.indep ? 8'h00 :
                           8'(st.period_a - st.period_b);
  assign ch_b.ontime_new = st.ontime_b;

  aux_pwm_channel gen_a (
    .pclk    (pclk),
    .presetn (presetn),
    .ch      (ch_a)
  );

  aux_pwm_channel gen_b (
    .pclk    (pclk),
    .presetn (presetn),
    .ch      (ch_b)
  );

  assign pwm_out_a = ch_a.pwm;
  assign pwm_out_b = ch_b.pwm;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  tick_spacing_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tick |=> !tick)
    else $error("ticks closer than two clocks");

  write_restart_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_access && (sel == SEL_PERIOD_A || sel == SEL_PERIOD_B))
    |=> st.restart ##1 (ch_a.count == 8'h00))
    else $error("period write did not clear timer");

  period_wrap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick && ch_a.count == st.period_a && !wr_access)
    |=> (ch_a.count == 8'h00))
    else $error("channel a missed its wrap");

  offset_phase_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.restart && !st.indep)
    |=> (ch_b.count == 8'(st.period_a - st.period_b)))
    else $error("offset start phase wrong");

  offset_share_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!st.indep && tick && ch_b.count == st.period_a &&
     !st.restart && !wr_access)
    |=> (ch_b.count == 8'h00))
    else $error("offset channel not on period a");

  zero_duty_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick && ch_a.count == st.period_a && st.ontime_a == 8'h00
     && !st.restart)
    |=> !pwm_out_a)
    else $error("zero on-time drove output");

  full_duty_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick && ch_a.count == st.period_a &&
     st.ontime_a > st.period_a && !st.restart && !wr_access)
    |=> pwm_out_a [*2])
    else $error("long on-time not at full duty");

  mode_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_access && sel == SEL_MODE)
    |=> (st.indep == $past(pwdata[MODE_INDEP_BIT])))
    else $error("mode bit not taken");

  indep_decouple_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.indep && tick && ch_b.count == st.period_b &&
     !st.restart && !wr_access)
    |=> (ch_b.count == 8'h00))
    else $error("independent b not on own period");

  reset_values_a: assert property (
    @(posedge pclk)
    $rose(presetn) |-> (st.period_a == PERIOD_RST &&
      st.period_b == PERIOD_RST && st.ontime_a == ONTIME_RST &&
      st.ontime_b == ONTIME_RST && st.indep == MODE_RST))
    else $error("register reset values wrong");

  count_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!tick && !st.restart)
    |=> ($stable(ch_a.count) && $stable(ch_b.count)))
    else $error("timer moved without a tick");

  ontime_take_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_access && sel == SEL_ONTIME_A)
    |=> (st.ontime_a == $past(pwdata[7:0])))
    else $error("on-time write not taken");

  period_take_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_access && sel == SEL_PERIOD_B)
    |=> (st.period_b == $past(pwdata[7:0])))
    else $error("period write not taken");

  ontime_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_access && (sel == SEL_ONTIME_A || sel == SEL_ONTIME_B))
    |=> !st.restart)
    else $error("on-time write restarted timers");

  indep_restart_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (st.restart && st.indep)
    |=> (ch_b.count == 8'h00))
    else $error("independent b not cleared");

  zero_duty_b_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick && ch_b.count >= ch_b.period && st.ontime_b == 8'h00
     && !st.restart)
    |=> !pwm_out_b)
    else $error("zero on-time drove output b");

  full_duty_b_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (tick && ch_b.count >= ch_b.period &&
     st.ontime_b > ch_b.period && !st.restart)
    |=> pwm_out_b)
    else $error("long on-time b not at full duty");

  restart_tick_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.restart |=> !tick ##1 (tick || st.restart))
    else $error("first unit after restart not two clocks");

endmodule : dual_aux_pwm_timer

// ===== inc/aux_pwm_pkg.sv
package aux_pwm_pkg;

  // ----------------------------------------
  // bus and register map
  // ----------------------------------------
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam logic [7:0]  PERIOD_A_OFS   = 8'h00;
  localparam logic [7:0]  PERIOD_B_OFS   = 8'h04;
  localparam logic [7:0]  ONTIME_A_OFS   = 8'h08;
  localparam logic [7:0]  ONTIME_B_OFS   = 8'h0c;
  localparam logic [7:0]  MODE_CTRL_OFS  = 8'h10;
  localparam logic [7:0]  STATUS_OFS     = 8'h14;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int          MODE_INDEP_BIT = 8;
  localparam logic        MODE_RST       = 1'b0;
  localparam logic [7:0]  PERIOD_RST     = 8'hff;
  localparam logic [7:0]  ONTIME_RST     = 8'h00;
  localparam int          STAT_PWM_A_BIT = 0;
  localparam int          STAT_PWM_B_BIT = 1;
  localparam int          STAT_CNT_A_LSB = 8;
  localparam int          STAT_CNT_B_LSB = 16;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int TIMEBASE_CLKS  = 2;
  localparam int TIMEBASE_NS    = TIMEBASE_CLKS * CLK_PERIOD_NS;
  localparam int TICK_CYCLES    =
    (TIMEBASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic TICK_LAST    = 1'(TICK_CYCLES - 1);

  // ----------------------------------------
  // register select
  // ----------------------------------------
  typedef enum {
    SEL_PERIOD_A,
    SEL_PERIOD_B,
    SEL_ONTIME_A,
    SEL_ONTIME_B,
    SEL_MODE,
    SEL_STATUS,
    SEL_NONE
  } reg_sel_t;

endpackage : aux_pwm_pkg

// ===== inc/pwm_chan_if.sv
`timescale 1ns/100ps
interface pwm_chan_if;
  logic       tick;
  logic       restart;
  logic [7:0] period;
  logic [7:0] init_count;
  logic [7:0] ontime_new;
  logic [7:0] count;
  logic       pwm;

  modport ctrl (
    output tick, restart, period, init_count, ontime_new,
    input  count, pwm
  );
  modport chan (
    input  tick, restart, period, init_count, ontime_new,
    output count, pwm
  );
endinterface : pwm_chan_if

// ===== hdl/aux_pwm_channel.sv
`timescale 1ns/100ps
module aux_pwm_channel (
  input wire logic pclk,
  input wire logic presetn,
  pwm_chan_if.chan ch
);
  import aux_pwm_pkg::*;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] ontime_act;
    logic       armed;
    logic       pwm;
  } chan_state_t;

  chan_state_t st;
  chan_state_t next_st;
  logic        wrap;

  // ----------------------------------------
  // cycle engine
  // ----------------------------------------
  // >= keeps a stale count from running away
  assign wrap = ch.tick && (st.count >= ch.period);

  always_comb begin
    next_st = st;
    if (ch.restart) begin
      next_st.count      = ch.init_count;
      next_st.ontime_act = ch.ontime_new;
      next_st.armed      = (ch.init_count == 8'h00);
      next_st.pwm        = (ch.init_count == 8'h00) &&
                           (ch.ontime_new != 8'h00);
    end else if (wrap) begin
      next_st.count      = 8'h00;
      next_st.ontime_act = ch.ontime_new;
      next_st.armed      = 1'b1;
      next_st.pwm        = (ch.ontime_new != 8'h00);
    end else if (ch.tick) begin
      next_st.count = st.count + 8'h01;
      next_st.pwm   = st.armed &&
        ({1'b0, st.count} + 9'h001 < {1'b0, st.ontime_act});
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{count: 8'h00, ontime_act: ONTIME_RST,
             armed: 1'b1, pwm: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign ch.count = st.count;
  assign ch.pwm   = st.pwm;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  rise_at_start_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(st.pwm) |-> (st.count == 8'h00))
    else $error("pwm rose away from cycle start");

  ontime_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!ch.restart && !wrap) |=> $stable(st.ontime_act))
    else $error("on-time changed mid cycle");

endmodule : aux_pwm_channel

// ===== verification/pwm_load_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// far-side load: times each pwm cycle
// ----------------------------------------
module pwm_load_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pin,
  output      logic        rise,
  output      logic [15:0] hi_len,
  output      logic [15:0] per_len
);
  logic        prev;
  logic [15:0] hi_cnt;
  logic [15:0] per_cnt;

  // lengths reported at each rising edge cover the cycle just ended
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev    <= 1'b0;
      rise    <= 1'b0;
      hi_len  <= 16'h0000;
      per_len <= 16'h0000;
      hi_cnt  <= 16'h0000;
      per_cnt <= 16'h0000;
    end else begin
      prev <= pin;
      rise <= pin && !prev;
      if (pin && !prev) begin
        hi_len  <= hi_cnt;
        per_len <= per_cnt;
        hi_cnt  <= 16'h0001;
        per_cnt <= 16'h0001;
      end else begin
        per_cnt <= per_cnt + 16'h0001;
        hi_cnt  <= hi_cnt + {15'h0000, pin};
      end
    end
  end
endmodule : pwm_load_model

// ===== verification/test_dual_aux_pwm_timer.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module test_dual_aux_pwm_timer;
  import aux_pwm_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite;
  logic              pready, pslverr, pwm_out_a, pwm_out_b;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              rise_a, rise_b;
  logic [15:0]       hi_a, per_a, hi_b, per_b;
  logic [15:0]       seed = 16'h44b0;
  logic [DATA_W+1:0] note;
  logic [DATA_W+1:0] note_q[$];
  int                fail_count = 0;
  int                checks = 0;
  int                pa, pb, oa, ob, n;

  dual_aux_pwm_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b));
  pwm_load_model i_load_a (.pclk(pclk), .presetn(presetn), .pin(pwm_out_a),
    .rise(rise_a), .hi_len(hi_a), .per_len(per_a));
  pwm_load_model i_load_b (.pclk(pclk), .presetn(presetn), .pin(pwm_out_b),
    .rise(rise_b), .hi_len(hi_b), .per_len(per_b));

  // ----------------------------------------
  // stimulus helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic err);
    note_q.push_back({wr, err, d});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wr ? d : {rnd(), rnd()};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_rise(input bit b);
    int k;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while ((b ? rise_b : rise_a) !== 1'b1 && k < 2000);
    if (k >= 2000) `CHK(1'b0, 1'b1)
  endtask : wait_rise

  task automatic level_count(input bit b, input int cyc, output int hi);
    hi = 0;
    repeat (cyc) begin
      @(negedge pclk);
      hi += ((b ? pwm_out_b : pwm_out_a) === 1'b1);
    end
  endtask : level_count

  // ----------------------------------------
  // result watcher: oldest note per transfer
  // ----------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (note_q.size() == 0) `CHK(1'b0, 1'b1)
      else begin
        note = note_q.pop_front();
        `CHK(pslverr, note[DATA_W])
        if (!note[DATA_W+1] && !note[DATA_W])
          `CHK(prdata, note[DATA_W-1:0])
      end
    end
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // hang guard, well beyond the expected few thousand cycles
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = '0; pwdata = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, PERIOD_A_OFS, 32'hff, 0);
    apb(0, PERIOD_B_OFS, 32'hff, 0);
    apb(0, ONTIME_A_OFS, 32'h0, 0);
    apb(0, ONTIME_B_OFS, 32'h0, 0);
    apb(0, MODE_CTRL_OFS, 32'h0, 0);
    apb(0, 8'h18, 32'h0, 1);
    apb(1, STATUS_OFS, 32'h0, 1);
    apb(1, MODE_CTRL_OFS, 32'h100, 0);
    apb(0, MODE_CTRL_OFS, 32'h100, 0);
    for (int k = 0; k < 3; k++) begin
      pa = 8 + rnd() % 24; oa = 1 + rnd() % (pa - 1);
      pb = 1 + rnd() % 24; ob = 1 + rnd() % pb;
      if (k == 0) begin pb = 1; ob = 1; end
      apb(1, PERIOD_A_OFS, {rnd(), 8'(rnd()), 8'(pa)}, 0);
      apb(1, ONTIME_A_OFS, 32'(oa), 0);
      apb(1, PERIOD_B_OFS, 32'(pb), 0);
      apb(1, ONTIME_B_OFS, 32'(ob), 0);
      apb(0, PERIOD_A_OFS, 32'(pa), 0);
      wait_rise(0); wait_rise(0);
      `CHK(per_a, 16'(2 * (pa + 1)))
      `CHK(hi_a, 16'(2 * oa))
      wait_rise(1); wait_rise(1);
      `CHK(per_b, 16'(2 * (pb + 1)))
      `CHK(hi_b, 16'(2 * ob))
    end
    apb(1, PERIOD_A_OFS, 32'd20, 0);
    apb(1, ONTIME_A_OFS, 32'd30, 0);
    apb(1, PERIOD_B_OFS, 32'd0, 0);
    apb(1, ONTIME_B_OFS, 32'd1, 0);
    repeat (100) @(negedge pclk);
    level_count(0, 200, n);
    `CHK(n, 200)
    level_count(1, 200, n);
    `CHK(n, 200)
    apb(1, ONTIME_A_OFS, 32'd0, 0);
    repeat (100) @(negedge pclk);
    level_count(0, 200, n);
    `CHK(n, 0)
    apb(1, PERIOD_A_OFS, 32'd0, 0);
    apb(0, STATUS_OFS, 32'h2, 0);
    apb(1, PERIOD_A_OFS, 32'd40, 0);
    apb(1, ONTIME_A_OFS, 32'd10, 0);
    wait_rise(0); wait_rise(0);
    apb(1, ONTIME_A_OFS, 32'd3, 0);
    wait_rise(0);
    `CHK(hi_a, 16'd20)
    wait_rise(0);
    `CHK(hi_a, 16'd6)
    repeat (30) @(negedge pclk);
    apb(1, PERIOD_A_OFS, 32'd40, 0);
    wait_rise(0);
    `CHK(per_a < 16'd82, 1'b1)
    apb(1, MODE_CTRL_OFS, 32'h0, 0);
    for (int k = 0; k < 3; k++) begin
      pa = 20 + rnd() % 40;
      // offset kept below channel a period
      pb = (k == 0) ? 0 : rnd() % pa;
      apb(1, PERIOD_A_OFS, 32'(pa), 0);
      apb(1, PERIOD_B_OFS, 32'(pb), 0);
      apb(1, ONTIME_A_OFS, 32'd5, 0);
      apb(1, ONTIME_B_OFS, 32'd4, 0);
      wait_rise(0); wait_rise(0);
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (rise_b !== 1'b1 && n < 1000);
      `CHK(n, 2 * (pb + 1))
      wait_rise(1);
      `CHK(per_b, 16'(2 * (pa + 1)))
      `CHK(hi_b, 16'd8)
    end
    print_verdict();
  end
endmodule : test_dual_aux_pwm_timer
